/* core/spi_dual_master.sv */
// APB register file and two SPI master lanes
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
module spi_dual_master
  import spi_dual_pkg::*;
(
  // System
  input wire logic clk_sys,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interface 0 link
  output spi_pins_t if0_pins,
  input wire logic if0_serial_din,
  // Interface 1 link
  output spi_pins_t if1_pins,
  input wire logic if1_serial_din
);
  spi_setup_t setup [2]; // Settings per interface
  logic [7:0] shift_data_reg [2]; // Data register per interface
  logic dual_if_enable; // Arbiter enable
  logic [1:0] cs_pol; // Chip enable polarity per interface
  logic [1:0] wr_pulse; // Self-clearing begin-write
  logic [1:0] rd_pulse; // Self-clearing begin-read
  logic [1:0] busy;
  logic [1:0] done;
  logic [7:0] result [2];
  logic wr_en; // APB write strobe
  logic [31:0] next_prdata;
  logic mapped;

  // Single-cycle access; pready high for every address
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;

  // Compare an address with one register offset
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    is_reg = (a == ofs);
  endfunction : is_reg

  // Configuration and control registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < 2; i++) begin
        setup[i] <= '0;
        setup[i].bit_order_sel <= 1'b1;
        setup[i].cs_polarity <= 1'b1;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        setup[i].cs_polarity <= cs_pol[i];
      end
      if (wr_en && (is_reg(paddr, OFS_IF0_CONFIG) || is_reg(paddr, OFS_IF1_CONFIG))) begin
        for (int i = 0; i < 2; i++) begin
          if (is_reg(paddr, i == 0 ? OFS_IF0_CONFIG : OFS_IF1_CONFIG)) begin
            setup[i].bit_order_sel <= pwdata[CFG_BIT_ORDER];
            setup[i].clk_idle_level <= pwdata[CFG_IDLE_LEVEL];
            setup[i].capture_edge_sel <= pwdata[CFG_CAPTURE_EDGE];
            setup[i].launch_edge_sel <= pwdata[CFG_LAUNCH_EDGE];
            setup[i].float_all_pins <= pwdata[CFG_FLOAT_ALL];
            setup[i].clk_div_sel <= pwdata[CFG_DIV_LSB +: 3];
          end
        end
      end
      for (int i = 0; i < 2; i++) begin
        if (wr_en && is_reg(paddr, i == 0 ? OFS_IF0_CONTROL : OFS_IF1_CONTROL)) begin
          setup[i].float_dout_after_write <= pwdata[CTL_FLOAT_DOUT];
          setup[i].chip_enable <= pwdata[CTL_CHIP_ENABLE];
        end
      end
    end
  end

  // Arbiter register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dual_if_enable <= 1'b0;
      cs_pol <= POL_RESET;
    end else if (wr_en && is_reg(paddr, OFS_ARBITER)) begin
      dual_if_enable <= pwdata[ARB_DUAL_ENABLE];
      cs_pol <= {pwdata[ARB_IF1_POL], pwdata[ARB_IF0_POL]};
    end
  end

  // Start pulses last one cycle; ignored by the lane while busy
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_pulse <= 2'b00;
      rd_pulse <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_en && is_reg(paddr, i == 0 ? OFS_IF0_CONTROL : OFS_IF1_CONTROL)) begin
          wr_pulse[i] <= pwdata[CTL_BEGIN_WRITE];
          rd_pulse[i] <= pwdata[CTL_BEGIN_READ];
        end else begin
          wr_pulse[i] <= 1'b0;
          rd_pulse[i] <= 1'b0;
        end
      end
    end
  end

  // Data registers; a finished transfer overwrites with received bits
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      shift_data_reg[0] <= 8'h00;
      shift_data_reg[1] <= 8'h00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (done[i]) begin
          shift_data_reg[i] <= result[i];
        end else if (wr_en && !busy[i]
                     && is_reg(paddr, i == 0 ? OFS_IF0_DATA : OFS_IF1_DATA)) begin
          shift_data_reg[i] <= pwdata[7:0];
        end
      end
    end
  end

  // Two lanes; interface 1 runs only with the arbiter enabled
  spi_lane u_lane0 (
    .clk_sys(clk_sys),
    .reset(reset),
    .setup(setup[0]),
    .start_write(wr_pulse[0]),
    .start_read(rd_pulse[0]),
    .allowed(1'b1),
    .load_data(shift_data_reg[0]),
    .busy(busy[0]),
    .done(done[0]),
    .result_data(result[0]),
    .pins(if0_pins),
    .serial_din(if0_serial_din)
  );

  spi_lane u_lane1 (
    .clk_sys(clk_sys),
    .reset(reset),
    .setup(setup[1]),
    .start_write(wr_pulse[1]),
    .start_read(rd_pulse[1]),
    .allowed(dual_if_enable),
    .load_data(shift_data_reg[1]),
    .busy(busy[1]),
    .done(done[1]),
    .result_data(result[1]),
    .pins(if1_pins),
    .serial_din(if1_serial_din)
  );

  // Read mux; reserved bits read zero
  always_comb begin
    next_prdata = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      OFS_IF0_STATUS: next_prdata[0] = busy[0];
      OFS_IF1_STATUS: next_prdata[0] = busy[1];
      OFS_IF0_CONFIG, OFS_IF1_CONFIG: begin
        for (int i = 0; i < 2; i++) begin
          if (paddr == (i == 0 ? OFS_IF0_CONFIG : OFS_IF1_CONFIG)) begin
            next_prdata[CFG_BIT_ORDER] = setup[i].bit_order_sel;
            next_prdata[CFG_IDLE_LEVEL] = setup[i].clk_idle_level;
            next_prdata[CFG_CAPTURE_EDGE] = setup[i].capture_edge_sel;
            next_prdata[CFG_LAUNCH_EDGE] = setup[i].launch_edge_sel;
            next_prdata[CFG_FLOAT_ALL] = setup[i].float_all_pins;
            next_prdata[CFG_DIV_LSB +: 3] = setup[i].clk_div_sel;
          end
        end
      end
      OFS_IF0_CONTROL: begin
        next_prdata[CTL_FLOAT_DOUT] = setup[0].float_dout_after_write;
        next_prdata[CTL_CHIP_ENABLE] = setup[0].chip_enable;
      end
      OFS_IF1_CONTROL: begin
        next_prdata[CTL_FLOAT_DOUT] = setup[1].float_dout_after_write;
        next_prdata[CTL_CHIP_ENABLE] = setup[1].chip_enable;
      end
      OFS_IF0_DATA: next_prdata[7:0] = shift_data_reg[0];
      OFS_IF1_DATA: next_prdata[7:0] = shift_data_reg[1];
      OFS_ARBITER: begin
        next_prdata[ARB_DUAL_ENABLE] = dual_if_enable;
        next_prdata[ARB_IF1_POL] = cs_pol[1];
        next_prdata[ARB_IF0_POL] = cs_pol[0];
      end
      default: mapped = 1'b0;
    endcase
  end

  // Read data from flip-flops, captured in the setup cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // Unmapped addresses answer with an error in the access phase
  assign pslverr = psel && penable && !mapped;
endmodule : spi_dual_master

/* common/spi_dual_pkg.sv */
// Shared constants and types for the dual SPI master controller
package spi_dual_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_IF0_STATUS = 8'h00;
  localparam logic [7:0] OFS_IF0_CONFIG = 8'h10;
  localparam logic [7:0] OFS_IF0_CONTROL = 8'h14;
  localparam logic [7:0] OFS_IF0_DATA = 8'h20;
  localparam logic [7:0] OFS_IF1_STATUS = 8'h40;
  localparam logic [7:0] OFS_IF1_CONFIG = 8'h50;
  localparam logic [7:0] OFS_IF1_CONTROL = 8'h54;
  localparam logic [7:0] OFS_IF1_DATA = 8'h60;
  localparam logic [7:0] OFS_ARBITER = 8'hF0;
  // Configuration field positions
  localparam int CFG_BIT_ORDER = 8;
  localparam int CFG_IDLE_LEVEL = 6;
  localparam int CFG_CAPTURE_EDGE = 5;
  localparam int CFG_LAUNCH_EDGE = 4;
  localparam int CFG_FLOAT_ALL = 3;
  localparam int CFG_DIV_LSB = 0;
  // Control field positions
  localparam int CTL_FLOAT_DOUT = 3;
  localparam int CTL_BEGIN_WRITE = 2;
  localparam int CTL_BEGIN_READ = 1;
  localparam int CTL_CHIP_ENABLE = 0;
  // Arbiter field positions
  localparam int ARB_DUAL_ENABLE = 31;
  localparam int ARB_IF1_POL = 1;
  localparam int ARB_IF0_POL = 0;
  // Reset values and limits
  localparam logic [2:0] DIV_STOPPED = 3'h7;
  localparam logic [3:0] BITS_PER_XFER = 4'h8;
  localparam logic [1:0] POL_RESET = 2'h3;

  // Per-interface software settings
  typedef struct packed {
    logic bit_order_sel;
    logic clk_idle_level;
    logic capture_edge_sel;
    logic launch_edge_sel;
    logic float_all_pins;
    logic [2:0] clk_div_sel;
    logic float_dout_after_write;
    logic chip_enable;
    logic cs_polarity;
  } spi_setup_t;

  // Pins of one interface
  typedef struct packed {
    logic serial_clk_out;
    logic serial_clk_oe;
    logic chip_enable_pin;
    logic chip_enable_oe;
    logic serial_dout;
    logic serial_dout_oe;
  } spi_pins_t;
endpackage : spi_dual_pkg

/* core/spi_rate_gen.sv */
// Clock divider giving one-cycle half-period enables for one interface
`timescale 1ns/1ns
module spi_rate_gen
  import spi_dual_pkg::*;
(
  // System
  input wire logic clk_sys,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic [2:0] clk_div_sel,
  // Output
  output logic half_tick
);
  logic [5:0] count; // Half-period counter

  // Half period limit: /2 toggles each cycle, /128 every 64
  function automatic logic [5:0] half_limit(input logic [2:0] sel);
    half_limit = 6'(({5'h00, 1'b1} << sel) - 6'h01);
  endfunction : half_limit

  // Count while running; code 7 never ticks, so the serial clock stands
  always_ff @(posedge clk_sys) begin
    if (reset || !run || clk_div_sel == DIV_STOPPED) begin
      count <= 6'h00;
    end else if (count >= half_limit(clk_div_sel)) begin
      count <= 6'h00;
    end else begin
      count <= count + 6'h01;
    end
  end

  assign half_tick = run && clk_div_sel != DIV_STOPPED
                     && count >= half_limit(clk_div_sel);
endmodule : spi_rate_gen

/* core/spi_lane.sv */
// One SPI master lane: eight-bit shifter with edge selection
`timescale 1ns/1ns
module spi_lane
  import spi_dual_pkg::*;
(
  // System
  input wire logic clk_sys,
  input wire logic reset,
  // Settings and start
  input spi_setup_t setup,
  input wire logic start_write,
  input wire logic start_read,
  input wire logic allowed,
  input wire logic [7:0] load_data,
  // Status
  output logic busy,
  output logic done,
  output logic [7:0] result_data,
  // Link
  output spi_pins_t pins,
  input wire logic serial_din
);
  typedef enum {IDLE, SHIFT} lane_state_t;
  lane_state_t state; // Lane state
  logic sck; // Internal serial clock level
  logic is_read; // Current transfer is a read
  logic dout; // Launched bit
  logic dout_held; // Pin still driven after a write
  logic [7:0] shifter; // Shift register
  logic [3:0] captured; // Bits captured so far
  logic half_tick; // Half-period enable
  logic rising; // Next tick is a rising edge
  logic launch_now;
  logic capture_now;
  logic first_bit;

  spi_rate_gen u_rate (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(state == SHIFT),
    .clk_div_sel(setup.clk_div_sel),
    .half_tick(half_tick)
  );

  // Edge classification from the next clock level
  assign rising = (sck == 1'b0);
  assign launch_now = half_tick && (rising == !setup.launch_edge_sel);
  assign capture_now = half_tick && (rising == !setup.capture_edge_sel);
  assign first_bit = setup.bit_order_sel ? shifter[7] : shifter[0];

  // Transfer sequencing; busy ignores new starts, write beats read
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= IDLE;
      is_read <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        IDLE: begin
          if (allowed && (start_write || start_read)) begin
            state <= SHIFT;
            is_read <= !start_write;
          end
        end
        SHIFT: begin
          if (capture_now && captured == BITS_PER_XFER - 4'h1) begin
            state <= IDLE;
            done <= 1'b1;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // Gated serial clock, rests at idle level outside transfers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sck <= 1'b0;
    end else if (state != SHIFT) begin
      sck <= setup.clk_idle_level;
    end else if (half_tick) begin
      sck <= !sck;
    end
  end

  // Shift register: load at start, launch and capture during transfer
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      shifter <= 8'h00;
      captured <= 4'h0;
      dout <= 1'b0;
    end else if (state == IDLE) begin
      captured <= 4'h0;
      if (allowed && (start_write || start_read)) begin
        shifter <= load_data;
        dout <= setup.bit_order_sel ? load_data[7] : load_data[0];
      end
    end else begin
      if (launch_now && !capture_now) begin
        dout <= first_bit;
      end
      if (capture_now) begin
        captured <= captured + 4'h1;
        if (setup.bit_order_sel) begin
          shifter <= {shifter[6:0], serial_din};
        end else begin
          shifter <= {serial_din, shifter[7:1]};
        end
      end
      if (launch_now && capture_now) begin
        dout <= setup.bit_order_sel ? shifter[6] : shifter[1];
      end
    end
  end

  // Data-out drive after a completed write
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dout_held <= 1'b0;
    end else if (state == SHIFT) begin
      dout_held <= !is_read;
    end else if (is_read) begin
      dout_held <= 1'b0;
    end
  end

  // Received byte lands in the lower bits of the data register
  assign result_data = shifter;
  assign busy = (state == SHIFT);

  // Pin drive and polarity
  always_comb begin
    pins.serial_clk_out = sck;
    pins.serial_clk_oe = !setup.float_all_pins;
    pins.chip_enable_pin = setup.chip_enable ~^ setup.cs_polarity;
    pins.chip_enable_oe = !setup.float_all_pins;
    pins.serial_dout = dout;
    if (state == SHIFT) begin
      pins.serial_dout_oe = !is_read;
    end else begin
      pins.serial_dout_oe = dout_held && !setup.float_dout_after_write;
    end
  end
endmodule : spi_lane

/* verif/spi_dual_monitor.sv */
// Port checker for the dual SPI master
`timescale 1ns/1ns
module spi_dual_monitor
  import spi_dual_pkg::*;
(
  // System
  input wire logic clk_sys,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Links
  input spi_pins_t if0_pins,
  input wire logic if0_serial_din,
  input spi_pins_t if1_pins,
  input wire logic if1_serial_din
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic idle0, flt0, cs0, pol0, dual; // Shadow settings
  logic [2:0] div0;
  wire wr = psel && penable && pwrite;
  wire ctl0 = wr && paddr == OFS_IF0_CONTROL;
  wire st0 = ctl0 && pwdata[CTL_BEGIN_WRITE];
  wire rd0 = ctl0 && pwdata[CTL_BEGIN_READ] && !pwdata[CTL_BEGIN_WRITE];
  wire st1 = wr && paddr == OFS_IF1_CONTROL && |pwdata[2:1];
  wire mapped = paddr inside {OFS_IF0_STATUS, OFS_IF0_CONFIG, OFS_IF0_CONTROL,
    OFS_IF0_DATA, OFS_IF1_STATUS, OFS_IF1_CONFIG, OFS_IF1_CONTROL, OFS_IF1_DATA, OFS_ARBITER};
  // Follows writes at the edge the registers take them
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      {idle0, flt0, cs0, dual} <= 4'h0;
      pol0 <= 1'b1;
      div0 <= 3'h0;
    end else if (wr) begin
      if (paddr == OFS_IF0_CONFIG) begin
        idle0 <= pwdata[CFG_IDLE_LEVEL];
        flt0 <= pwdata[CFG_FLOAT_ALL];
        div0 <= pwdata[2:0];
      end
      if (ctl0) cs0 <= pwdata[CTL_CHIP_ENABLE];
      if (paddr == OFS_ARBITER) begin
        dual <= pwdata[ARB_DUAL_ENABLE];
        pol0 <= pwdata[ARB_IF0_POL];
      end
    end
  end
  pready_a: assert property (pready) else $error("pready low");
  unmapped_err_a: assert property (psel && penable && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  idle_clk_a: assert property ((!cs0 && !flt0 && $stable(idle0))[*3] |->
    if0_pins.serial_clk_out == idle0) else $error("clock not at idle level");
  cs_level_a: assert property (($stable({cs0, pol0}))[*3] |->
    if0_pins.chip_enable_pin == (cs0 ~^ pol0)) else $error("chip enable level wrong");
  float_pins_a: assert property (($stable(flt0))[*3] |-> if0_pins.serial_clk_oe != flt0
    && if0_pins.chip_enable_oe != flt0) else $error("pin enables wrong");
  // Busy shows two edges after the start write; the pin may still drive before then
  read_float_a: assert property (rd0 |=> ##1 (!if0_pins.serial_dout_oe)[*8])
    else $error("data out driven in read");
  if1_block_a: assert property (st1 && !dual |=>
    ($stable(if1_pins.serial_clk_out))[*8]) else $error("interface 1 ran while blocked");
  start_clk_a: assert property (st0 && div0 != DIV_STOPPED |->
    ##[1:200] $changed(if0_pins.serial_clk_out)) else $error("no clock after start");
  stopped_a: assert property (st0 && div0 == DIV_STOPPED |=>
    ($stable(if0_pins.serial_clk_out))[*8]) else $error("stopped clock toggled");
endmodule : spi_dual_monitor

/* verif/spi_slave_model.sv */
// Behavioural SPI slave on one link
`timescale 1ns/1ns
module spi_slave_model
  import spi_dual_pkg::*;
(
  // System
  input wire logic clk_sys,
  // Link and mode
  input spi_pins_t pins,
  input wire logic cap_fall,
  input wire logic msb,
  input wire logic act_high,
  input wire logic [7:0] tx,
  // Results
  output logic din,
  output logic [7:0] rx
);
  logic sk; // Last clock level seen
  logic tgl = 1'b0; // Filler so a stale level never passes
  logic [7:0] sh; // Reply shifter
  wire on = pins.chip_enable_oe && pins.chip_enable_pin == act_high;
  wire edg = on && sk != pins.serial_clk_out;
  assign din = on ? (msb ? sh[7] : sh[0]) : tgl;
  // Take bits on capture edges, move reply on the others
  always @(posedge clk_sys) begin
    sk <= pins.serial_clk_out;
    tgl <= !tgl;
    if (!on) sh <= tx;
    else if (edg && (pins.serial_clk_out ^ cap_fall))
      rx <= msb ? {rx[6:0], pins.serial_dout} : {pins.serial_dout, rx[7:1]};
    else if (edg) sh <= msb ? sh << 1 : sh >> 1;
  end
endmodule : spi_slave_model

/* verif/tb.sv */
// Self-checking bench for the dual SPI master
`timescale 1ns/1ns
module tb;
  import spi_dual_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, err, din0, din1, sk, cf = 1'b0, ms = 1'b1, ah1 = 1'b1;
  logic [7:0] rx0, rx1;
  spi_pins_t if0_pins, if1_pins;
  int mismatches = 0, compares = 0, tg = 0, cyc = 0, t1 = 0, tp = 0, n0 = 0;
  spi_dual_master u_dut(.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .if0_pins(if0_pins), .if0_serial_din(din0), .if1_pins(if1_pins),
    .if1_serial_din(din1));
  spi_slave_model u_m0(.clk_sys(clk_sys), .pins(if0_pins), .cap_fall(cf), .msb(ms),
    .act_high(1'b1), .tx(8'h96), .din(din0), .rx(rx0));
  spi_slave_model u_m1(.clk_sys(clk_sys), .pins(if1_pins), .cap_fall(cf), .msb(ms),
    .act_high(ah1), .tx(8'h5C), .din(din1), .rx(rx1));
  initial forever #25 clk_sys = ~clk_sys;
  // Counts interface 0 clock toggles; keeps the third half period of a transfer,
  // since the last half is cut short when busy drops
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    sk <= if0_pins.serial_clk_out;
    if (sk != if0_pins.serial_clk_out) begin
      tg <= tg + 1;
      t1 <= cyc;
      if (tg == n0 + 2) tp <= cyc - t1;
    end
  end
  task test_done;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // One APB transfer; psel drops a cycle between transfers
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask : rd
  task poll(input logic [7:0] b);
    r = 32'h1;
    for (int i = 0; i < 600 && r[0] !== 1'b0; i++) apb(1'b0, b, 32'h0);
    chk(r[0], 1'b0);
  endtask : poll
  // Chip enable on, start, wait, chip enable off, read data back
  task xfer(input logic [7:0] b, input logic [8:0] cfg, input logic [3:0] ctl,
    input logic [7:0] d);
    cf <= cfg[CFG_CAPTURE_EDGE];
    ms <= cfg[CFG_BIT_ORDER];
    apb(1'b1, b + OFS_IF0_CONFIG, {23'h0, cfg});
    apb(1'b1, b + OFS_IF0_DATA, {24'h0, d});
    apb(1'b1, b + OFS_IF0_CONTROL, {28'h0, ctl & 4'h9});
    n0 = tg;
    apb(1'b1, b + OFS_IF0_CONTROL, {28'h0, ctl});
    poll(b);
    apb(1'b1, b + OFS_IF0_CONTROL, {28'h0, ctl & 4'h8});
    apb(1'b0, b + OFS_IF0_DATA, 32'h0);
    @(negedge clk_sys);
  endtask : xfer
  initial begin
    repeat (40000) @(posedge clk_sys);
    mismatches++;
    test_done;
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    rd(OFS_ARBITER, 32'h3);
    apb(1'b0, OFS_IF1_CONFIG, 32'h0);
    chk(r[CFG_BIT_ORDER], 1'b1);
    rd(OFS_IF1_STATUS, 32'h0);
    rd(OFS_IF1_DATA, 32'h0);
    rd(OFS_IF1_CONTROL, 32'h0);
    rd(8'h08, 32'h0);
    chk(err, 1'b1);
    $display("test 1 done");
    for (int d = 0; d < 7; d++) begin
      xfer(8'h00, {6'h22, d[2:0]}, 4'h5, {5'h14, d[2:0]});
      chk(rx0, {5'h14, d[2:0]});
      chk(tg - n0, 16);
      chk(tp, 1 << d);
      chk(if0_pins.serial_dout_oe, 1'b1);
    end
    $display("test 2 done");
    xfer(8'h00, 9'h061, 4'hD, 8'h3C);
    chk(rx0, 8'h3C);
    chk(if0_pins.serial_dout_oe, 1'b0);
    $display("test 3 done");
    xfer(8'h00, 9'h112, 4'h3, 8'h0F);
    chk(r, 32'h96);
    $display("test 4 done");
    apb(1'b1, OFS_IF0_DATA, 32'h5A);
    apb(1'b1, OFS_IF0_CONTROL, 32'h7);
    n0 = tg;
    apb(1'b1, OFS_IF0_DATA, 32'hFF);
    apb(1'b1, OFS_IF0_CONTROL, 32'h7);
    rd(OFS_IF0_CONTROL, 32'h1);
    poll(8'h00);
    @(negedge clk_sys);
    chk(rx0, 8'h5A);
    chk(tg - n0, 16);
    apb(1'b1, OFS_IF0_CONTROL, 32'h0);
    $display("test 5 done");
    apb(1'b1, OFS_IF1_CONTROL, 32'h5);
    rd(OFS_IF1_STATUS, 32'h0);
    apb(1'b1, OFS_ARBITER, 32'h80000001);
    ah1 <= 1'b0;
    xfer(OFS_IF1_STATUS, 9'h111, 4'h5, 8'h69);
    chk(rx1, 8'h69);
    chk(if1_pins.chip_enable_pin, 1'b1);
    $display("test 6 done");
    apb(1'b1, OFS_IF0_CONFIG, 32'h8);
    rd(OFS_IF0_CONFIG, 32'h8);
    @(negedge clk_sys);
    chk({if0_pins.serial_clk_oe, if0_pins.chip_enable_oe}, 2'b00);
    apb(1'b1, OFS_IF0_CONFIG, 32'h0);
    rd(OFS_IF0_CONFIG, 32'h0);
    @(negedge clk_sys);
    chk({if0_pins.serial_clk_oe, if0_pins.chip_enable_oe}, 2'b11);
    $display("test 7 done");
    apb(1'b1, OFS_IF0_CONFIG, 32'h117);
    apb(1'b1, OFS_IF0_CONTROL, 32'h5);
    repeat (20) @(posedge clk_sys);
    rd(OFS_IF0_STATUS, 32'h1);
    reset <= 1'b1;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    rd(OFS_IF0_STATUS, 32'h0);
    $display("test 8 done");
    test_done;
  end
endmodule : tb
bind spi_dual_master spi_dual_monitor u_mon (.*);
